/* File: common/alu_pkg.sv */
// Shared constants and types for the accumulator and pointer datapath
package alu_pkg;

   // Bus geometry
   localparam int ADR_W = 10;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;

   // Data memory geometry
   localparam int MEM_W = 8;
   localparam int MEM_DEPTH = 128;
   localparam int MEM_AW = 7;
   localparam int MEM_WIN_BIT = 9;
   localparam int MEM_IDX_LSB = 2;

   // Register byte offsets
   localparam logic [ADR_W-1:0] OFS_ACC = 10'h000;
   localparam logic [ADR_W-1:0] OFS_STATUS = 10'h004;
   localparam logic [ADR_W-1:0] OFS_PTR0 = 10'h008;
   localparam logic [ADR_W-1:0] OFS_PTR_STEP = 10'h004;
   localparam logic [ADR_W-1:0] OFS_CMD = 10'h010;

   // Status flag positions
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_W = 3;

   // Command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int OP_W = 3;
   localparam int CMD_DEST_BIT = 3;
   localparam int CMD_PSEL_BIT = 4;
   localparam int CMD_OPND_LSB = 8;

   // Pointer geometry
   localparam int PTR_W = 16;
   localparam int PTR_N = 2;
   localparam int PTR_K_W = 6;

   // Operation codes
   localparam logic [OP_W-1:0] OP_PTR_ADD = 3'h0;
   localparam logic [OP_W-1:0] OP_AND_IMM = 3'h1;
   localparam logic [OP_W-1:0] OP_ADD_IMM = 3'h2;
   localparam logic [OP_W-1:0] OP_AND_MEM = 3'h3;
   localparam logic [OP_W-1:0] OP_ADD_MEM = 3'h4;
   localparam logic [OP_W-1:0] OP_ASR_MEM = 3'h5;

   // Reset values
   localparam logic [MEM_W-1:0] RST_ACC = 8'h00;
   localparam logic [FLG_W-1:0] RST_FLAGS = 3'h0;
   localparam logic [PTR_W-1:0] RST_PTR = 16'h0000;

   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_EXEC} alu_state_e;

endpackage

/* File: core/alu_mem.sv */
// Single-port data memory with registered read data
`timescale 1ns/1ps
module alu_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic re,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Array write
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   // Read data held in a register until the next read
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata <= '0;
      end else if (re) begin
         rdata <= mem[addr];
      end
   end

endmodule

/* File: core/alu_core.sv */
// Accumulator, pointer and data-memory datapath behind a Wishbone slave
//
// Notes on behaviour
// - Pointer add: sign-extended 6-bit step, flags untouched
// - Pointer sum wraps modulo 65536
// - AND immediate into accumulator, zero flag only
// - Add immediate into accumulator, C DC Z
// - AND memory byte 0..127, zero flag only
// - Target bit 0 accumulator, 1 memory
// - Add memory byte to accumulator, C DC Z
// - Shift keeps sign bit in bit 7
// - Shift result target follows target bit
// - Pointer add finishes in one cycle
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module alu_core (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [alu_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [alu_pkg::SEL_W-1:0] wb_sel_i,
   input wire logic [alu_pkg::DAT_W-1:0] wb_dat_i,
   output logic [alu_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   output logic alu_busy
);
   import alu_pkg::*;

   alu_state_e st;
   logic [MEM_W-1:0] acc;
   logic [FLG_W-1:0] flags;
   logic [PTR_W-1:0] ptr [PTR_N];
   logic [OP_W-1:0] cmd_op;
   logic cmd_dest;
   logic [MEM_W-1:0] cmd_opnd;
   logic rd_wait;
   logic idle, bus_req, is_mem, wr_reg, cmd_go;
   logic [OP_W-1:0] bus_op;
   logic bus_psel;
   logic [MEM_W-1:0] bus_opnd;
   logic bus_is_imm;
   logic bus_is_mem_op;
   logic launch_mem;
   logic ptr_go;
   logic [PTR_W-1:0] k_ext;
   logic [PTR_W-1:0] ptr_sum;
   logic [MEM_AW-1:0] mem_addr;
   logic mem_re;
   logic mem_we;
   logic [MEM_W-1:0] mem_wdata;
   logic [MEM_W-1:0] mem_rdata;
   logic [OP_W-1:0] alu_op;
   logic [MEM_W-1:0] alu_b;
   logic [MEM_W-1:0] alu_res;
   logic alu_c, alu_dc, alu_z;
   logic upd_c, upd_dc, upd_z;
   logic alu_fire;
   logic acc_wr;
   logic [DAT_W-1:0] reg_rdata;

   // Bus request decode
   assign idle = (st == ST_IDLE);
   assign alu_busy = ~idle;
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign is_mem = wb_adr_i[MEM_WIN_BIT];
   assign wr_reg = bus_req & idle & ~is_mem & wb_we_i;
   assign cmd_go = wr_reg & (wb_adr_i == OFS_CMD) & wb_sel_i[0] & wb_sel_i[1];

   // Command word fields as written
   assign bus_op = wb_dat_i[CMD_OP_LSB +: OP_W];
   assign bus_psel = wb_dat_i[CMD_PSEL_BIT];
   assign bus_opnd = wb_dat_i[CMD_OPND_LSB +: MEM_W];
   assign bus_is_imm = (bus_op == OP_AND_IMM) | (bus_op == OP_ADD_IMM);
   assign bus_is_mem_op = (bus_op == OP_AND_MEM) | (bus_op == OP_ADD_MEM)
                        | (bus_op == OP_ASR_MEM);
   assign launch_mem = cmd_go & bus_is_mem_op;
   assign ptr_go = cmd_go & (bus_op == OP_PTR_ADD);

   assign k_ext = {{(PTR_W-PTR_K_W){bus_opnd[PTR_K_W-1]}}, bus_opnd[PTR_K_W-1:0]};
   assign ptr_sum = ptr[bus_psel] + k_ext;

   // Wishbone answer: registers in one edge, memory reads in two
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         rd_wait <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= 1'b0;
         rd_wait <= 1'b0;
         if (bus_req && idle) begin
            if (!is_mem || wb_we_i) begin
               wb_ack_o <= 1'b1;
               wb_dat_o <= wb_we_i ? '0 : reg_rdata;
            end else if (!rd_wait) begin
               rd_wait <= 1'b1;
            end else begin
               wb_ack_o <= 1'b1;
               wb_dat_o <= {{(DAT_W-MEM_W){1'b0}}, mem_rdata};
            end
         end
      end
   end

   // Register read mux
   always_comb begin
      reg_rdata = '0;
      case (wb_adr_i)
         OFS_ACC: reg_rdata = {{(DAT_W-MEM_W){1'b0}}, acc};
         OFS_STATUS: reg_rdata = {{(DAT_W-FLG_W){1'b0}}, flags};
         OFS_PTR0: reg_rdata = {{(DAT_W-PTR_W){1'b0}}, ptr[0]};
         OFS_PTR0 + OFS_PTR_STEP: reg_rdata = {{(DAT_W-PTR_W){1'b0}}, ptr[1]};
         OFS_CMD: begin
            reg_rdata[CMD_OP_LSB +: OP_W] = cmd_op;
            reg_rdata[CMD_DEST_BIT] = cmd_dest;
            reg_rdata[CMD_OPND_LSB +: MEM_W] = cmd_opnd;
         end
         default: reg_rdata = '0;
      endcase
   end

   // Memory-operand sequencer: load, then execute
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= ST_IDLE;
      end else begin
         case (st)
            ST_IDLE: begin
               if (launch_mem) begin
                  st <= ST_LOAD;
               end
            end
            ST_LOAD: st <= ST_EXEC;
            ST_EXEC: st <= ST_IDLE;
            default: st <= ST_IDLE;
         endcase
      end
   end

   // Command capture
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cmd_op <= OP_PTR_ADD;
         cmd_dest <= 1'b0;
         cmd_opnd <= '0;
      end else if (cmd_go) begin
         cmd_op <= bus_op;
         cmd_dest <= wb_dat_i[CMD_DEST_BIT];
         cmd_opnd <= bus_opnd;
      end
   end

   // Memory port shared by the bus window and the sequencer
   // seven-bit operand address
   assign mem_addr = idle ? wb_adr_i[MEM_IDX_LSB +: MEM_AW] : cmd_opnd[MEM_AW-1:0];
   assign mem_re = (st == ST_LOAD) | (bus_req & idle & is_mem & ~wb_we_i & ~rd_wait);
   assign mem_we = ((st == ST_EXEC) & cmd_dest)
                 | (bus_req & idle & is_mem & wb_we_i & wb_sel_i[0]);
   assign mem_wdata = idle ? wb_dat_i[MEM_W-1:0] : alu_res;

   alu_mem #(
      .WIDTH(MEM_W),
      .DEPTH(MEM_DEPTH),
      .AW(MEM_AW)
   ) u_mem (
      .ref_clk(ref_clk),
      .reset(reset),
      .re(mem_re),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // Operand selection: immediate while idle, memory byte in execute
   assign alu_op = idle ? bus_op : cmd_op;
   assign alu_b = idle ? bus_opnd : mem_rdata;

   // Arithmetic and logic unit
   always_comb begin
      logic [MEM_W:0] sum;
      logic [4:0] nib;
      sum = {1'b0, acc} + {1'b0, alu_b};
      nib = {1'b0, acc[3:0]} + {1'b0, alu_b[3:0]};
      alu_res = acc;
      alu_c = flags[FLG_C];
      alu_dc = flags[FLG_DC];
      upd_c = 1'b0;
      upd_dc = 1'b0;
      upd_z = 1'b0;
      case (alu_op)
         OP_AND_IMM, OP_AND_MEM: begin
            alu_res = acc & alu_b;
            upd_z = 1'b1;
         end
         OP_ADD_IMM, OP_ADD_MEM: begin
            alu_res = sum[MEM_W-1:0];
            alu_c = sum[MEM_W];
            alu_dc = nib[4];
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
         end
         OP_ASR_MEM: begin
            alu_res = {alu_b[MEM_W-1], alu_b[MEM_W-1:1]};
            alu_c = alu_b[0];
            upd_c = 1'b1;
            upd_z = 1'b1;
         end
         default: alu_res = acc;
      endcase
      alu_z = (alu_res == '0);
   end

   assign alu_fire = (cmd_go & bus_is_imm) | (st == ST_EXEC);
   assign acc_wr = (cmd_go & bus_is_imm) | ((st == ST_EXEC) & ~cmd_dest);

   // Accumulator
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         acc <= RST_ACC;
      end else if (wr_reg && wb_adr_i == OFS_ACC && wb_sel_i[0]) begin
         acc <= wb_dat_i[MEM_W-1:0];
      end else if (acc_wr) begin
         acc <= alu_res;
      end
   end

   // Status flags: a bus write loads all three, otherwise each is updated only when its operation says so
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         flags <= RST_FLAGS;
      end else if (wr_reg && wb_adr_i == OFS_STATUS && wb_sel_i[0]) begin
         flags <= wb_dat_i[FLG_W-1:0];
      end else if (alu_fire) begin
         if (upd_c) begin
            flags[FLG_C] <= alu_c;
         end
         if (upd_dc) begin
            flags[FLG_DC] <= alu_dc;
         end
         if (upd_z) begin
            flags[FLG_Z] <= alu_z;
         end
      end
   end

   // Indirect pointer pairs, byte-writable, stepped by the pointer add
   for (genvar i = 0; i < PTR_N; i++) begin : g_ptr
      localparam logic [ADR_W-1:0] OFS_I = ADR_W'(OFS_PTR0 + OFS_PTR_STEP * i);
      always_ff @(posedge ref_clk or posedge reset) begin
         if (reset) begin
            ptr[i] <= RST_PTR;
         end else if (wr_reg && wb_adr_i == OFS_I) begin
            if (wb_sel_i[0]) begin
               ptr[i][7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               ptr[i][15:8] <= wb_dat_i[15:8];
            end
         end else if (ptr_go && bus_psel == 1'(i)) begin
            ptr[i] <= ptr_sum;
         end
      end
   end

   // Checks on the datapath behaviour
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence seq_launch;
      launch_mem;
   endsequence
   sequence seq_steps;
      (st == ST_LOAD) ##1 (st == ST_EXEC) ##1 (st == ST_IDLE);
   endsequence
   sequence seq_exec_to_acc;
      (st == ST_EXEC) && !cmd_dest;
   endsequence

   logic [PTR_W-1:0] chk_ptr0_next;
   logic [MEM_W:0] chk_sum9;
   assign chk_ptr0_next = ptr[0] + k_ext;
   assign chk_sum9 = {1'b0, acc} + {1'b0, bus_opnd};

   chk_ptr_add_wrap: assert property (
      ptr_go && !bus_psel |=> ptr[0] == $past(chk_ptr0_next))
      else $error("pointer add result wrong");
   chk_ptr_flags_kept: assert property (
      ptr_go |=> flags == $past(flags) && acc == $past(acc))
      else $error("pointer add touched flags");
   chk_ptr_one_cycle: assert property (
      ptr_go && bus_psel |=> ptr[1] == $past(ptr[1]) + $past(k_ext) && ptr[0] == $past(ptr[0]))
      else $error("pointer add not single cycle");
   chk_and_imm_z: assert property (
      cmd_go && bus_op == OP_AND_IMM
      |=> acc == ($past(acc) & $past(bus_opnd)) && flags[FLG_Z] == (acc == 8'h00)
          && flags[FLG_W-2:0] == $past(flags[FLG_W-2:0]))
      else $error("and immediate wrong");
   chk_add_imm_carry: assert property (
      cmd_go && bus_op == OP_ADD_IMM
      |=> {flags[FLG_C], acc} == $past(chk_sum9) && flags[FLG_Z] == (acc == 8'h00))
      else $error("add immediate wrong");
   chk_mem_op_steps: assert property (
      seq_launch |=> seq_steps)
      else $error("memory operation sequence wrong");
   chk_mem_target_mem: assert property (
      (st == ST_EXEC) && cmd_dest |-> mem_we ##1 acc == $past(acc))
      else $error("memory target not honoured");
   chk_shift_sign: assert property (
      seq_exec_to_acc and (cmd_op == OP_ASR_MEM)
      |=> acc[7] == acc[6] && flags[FLG_C] == $past(mem_rdata[0]))
      else $error("signed shift wrong");
   chk_zero_flag: assert property (
      alu_fire && upd_z |=> flags[FLG_Z] == ($past(alu_res) == 8'h00))
      else $error("zero flag wrong");

endmodule

/* File: tb/alu_arith_logic_ops_bench.sv */
// Self-checking bench for the accumulator, pointer and data-memory datapath
`timescale 1ns/1ps
module alu_arith_logic_ops_bench;
   import alu_pkg::*;

   typedef struct {
      logic [7:0] a;
      logic [7:0] m;
      logic [2:0] st;
      logic [15:0] cmd;
      logic [7:0] ea;
      logic [7:0] em;
      logic [2:0] es;
   } alu_row_s;

   logic ref_clk;
   logic reset;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [ADR_W-1:0] wb_adr_i;
   logic [SEL_W-1:0] wb_sel_i;
   logic [DAT_W-1:0] wb_dat_i;
   logic [DAT_W-1:0] wb_dat_o;
   logic wb_ack_o;
   logic alu_busy;
   logic [31:0] rd;
   int errors;
   int n_compared;

   // Rows: acc, mem byte, status, command, then expected acc, mem byte, status
   alu_row_s rows [12] = '{
      '{8'hf0, 8'h00, 3'h3, 16'h0f01, 8'h00, 8'h00, 3'h7},
      '{8'hf3, 8'h11, 3'h4, 16'h3c01, 8'h30, 8'h11, 3'h0},
      '{8'h08, 8'h22, 3'h0, 16'h0802, 8'h10, 8'h22, 3'h2},
      '{8'hff, 8'h33, 3'h0, 16'h0102, 8'h00, 8'h33, 3'h7},
      '{8'h80, 8'h44, 3'h7, 16'h8002, 8'h00, 8'h44, 3'h5},
      '{8'haa, 8'h0f, 3'h3, 16'h0503, 8'h0a, 8'h0f, 3'h3},
      '{8'h55, 8'haa, 3'h0, 16'h7f0b, 8'h55, 8'h00, 3'h4},
      '{8'h7f, 8'h01, 3'h0, 16'h0504, 8'h80, 8'h01, 3'h2},
      '{8'h90, 8'h90, 3'h0, 16'h050c, 8'h90, 8'h20, 3'h1},
      '{8'h00, 8'h81, 3'h2, 16'h0505, 8'hc0, 8'h81, 3'h3},
      '{8'h33, 8'h01, 3'h0, 16'h7f0d, 8'h33, 8'h00, 3'h5},
      '{8'h01, 8'h42, 3'h7, 16'h050d, 8'h01, 8'h21, 3'h2}
   };

   alu_core uut (
      .ref_clk(ref_clk),
      .reset(reset),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .alu_busy(alu_busy)
   );

   // Clock generator
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Compare one value and count the outcome
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Print counts and verdict, then end the run
   task automatic stop_test();
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One classic Wishbone cycle, held until ack is sampled high; the watchdog ends a hang
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge ref_clk);
      end while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   // Byte address of a data-memory location in the bus window
   function automatic logic [9:0] madr(input logic [6:0] i);
      return {1'b1, i, 2'b00};
   endfunction

   // Idle outputs and cleared registers after a reset
   task automatic reset_check();
      logic [9:0] ofs [5] = '{OFS_ACC, OFS_STATUS, OFS_PTR0, OFS_PTR0 + OFS_PTR_STEP, OFS_CMD};
      check({30'h0, wb_ack_o, alu_busy}, 32'h0);
      foreach (ofs[k]) begin
         bus(1'b0, ofs[k], 32'h0, 4'hf, rd);
         check(rd, 32'h0);
      end
   endtask

   // Watchdog against a hung handshake
   initial begin
      #40000;
      errors++;
      stop_test();
   end

   // Main sequence
   initial begin
      reset = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = '0;
      wb_sel_i = '0;
      wb_dat_i = '0;
      errors = 0;
      n_compared = 0;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      reset_check();
      // Row table of accumulator and memory operations
      foreach (rows[i]) begin
         bus(1'b1, OFS_ACC, {24'h0, rows[i].a}, 4'hf, rd);
         bus(1'b1, OFS_STATUS, {29'h0, rows[i].st}, 4'hf, rd);
         bus(1'b1, madr(rows[i].cmd[14:8]), {24'h0, rows[i].m}, 4'hf, rd);
         bus(1'b1, OFS_CMD, {16'h0, rows[i].cmd}, 4'hf, rd);
         bus(1'b0, OFS_ACC, 32'h0, 4'hf, rd);
         check(rd, {24'h0, rows[i].ea});
         bus(1'b0, OFS_STATUS, 32'h0, 4'hf, rd);
         check(rd, {29'h0, rows[i].es});
         bus(1'b0, madr(rows[i].cmd[14:8]), 32'h0, 4'hf, rd);
         check(rd, {24'h0, rows[i].em});
      end
      // Pointer add: negative step below zero, flags preset must survive
      bus(1'b1, OFS_STATUS, 32'h7, 4'hf, rd);
      bus(1'b1, OFS_PTR0, 32'h0, 4'hf, rd);
      bus(1'b1, OFS_PTR0 + OFS_PTR_STEP, 32'hfff0, 4'hf, rd);
      bus(1'b1, OFS_CMD, 32'h3f00, 4'hf, rd);
      bus(1'b0, OFS_PTR0, 32'h0, 4'hf, rd);
      check(rd, 32'hffff);
      // Largest positive step on the second pair, wrapping past the top
      bus(1'b1, OFS_CMD, 32'h1f10, 4'hf, rd);
      check({31'h0, alu_busy}, 32'h0);
      bus(1'b0, OFS_PTR0 + OFS_PTR_STEP, 32'h0, 4'hf, rd);
      check(rd, 32'h000f);
      // Most negative step, other pair untouched by the previous add
      bus(1'b1, OFS_CMD, 32'h2000, 4'hf, rd);
      bus(1'b0, OFS_PTR0, 32'h0, 4'hf, rd);
      check(rd, 32'hffdf);
      bus(1'b0, OFS_STATUS, 32'h0, 4'hf, rd);
      check(rd, 32'h7);
      // Back-to-back memory commands show busy between them and both land
      bus(1'b1, OFS_ACC, 32'h01, 4'hf, rd);
      bus(1'b1, madr(7'h09), 32'h01, 4'hf, rd);
      bus(1'b1, OFS_CMD, 32'h090c, 4'hf, rd);
      check({31'h0, alu_busy}, 32'h1);
      bus(1'b1, OFS_CMD, 32'h090c, 4'hf, rd);
      bus(1'b0, madr(7'h09), 32'h0, 4'hf, rd);
      check(rd, 32'h03);
      // Partial command write and unused op code leave the accumulator alone
      bus(1'b1, OFS_CMD, 32'h0001, 4'h1, rd);
      bus(1'b1, OFS_CMD, 32'h0006, 4'hf, rd);
      bus(1'b0, OFS_ACC, 32'h0, 4'hf, rd);
      check(rd, 32'h01);
      // Unmapped offset reads as zero
      bus(1'b1, 10'h014, 32'hff, 4'hf, rd);
      bus(1'b0, 10'h014, 32'h0, 4'hf, rd);
      check(rd, 32'h0);
      // Second reset in mid-run clears the registers again
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      reset_check();
      stop_test();
   end
endmodule
